// *** rxpf_crc16.sv ***
`timescale 1ns/100ps
`include "rxpf_regs.svh"
module rxpf_crc16 (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // bit feed
  input wire logic init,
  input wire logic bitEn,
  input wire logic bitIn,
  // running remainder
  output logic [15:0] crc
);
  logic [15:0] crc_q;
  logic fb;

  assign fb = crc_q[15] ^ bitIn;

  // serial remainder, msb first, non-zero seed
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      crc_q <= `RXPF_CRC_SEED;
    end else if (ce) begin
      if (init) begin
        crc_q <= `RXPF_CRC_SEED;
      end else if (bitEn) begin
        crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? `RXPF_CRC_POLY : 16'h0000);
      end
    end
  end

  assign crc = crc_q;
endmodule // rxpf_crc16

// *** rxpf_host_model.sv ***
`timescale 1ns/100ps
module rxpf_host_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // drain control and queue status
  input wire logic drainEn,
  input wire logic slow,
  input wire logic queueHasBytesFlag,
  // read request
  output logic rdReq
);
  // read while bytes wait, pause once the queue runs dry; slow reads every other cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdReq <= 1'b0;
    end else begin
      rdReq <= drainEn && queueHasBytesFlag && !(slow && rdReq);
    end
  end
endmodule // rxpf_host_model

// *** rxpf_line_dec.sv ***
`timescale 1ns/100ps
`include "rxpf_regs.svh"
module rxpf_line_dec (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // chip stream in, decoded bits out
  rxpf_line_if.dec lnk
);
  logic half_q;
  logic first_q;
  logic [8:0] lfsr_q;
  logic bitOut_q;
  logic bitValid_q;

  // turns payload chips into NRZ bits, one decode method at a time
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      half_q <= 1'b0;
      first_q <= 1'b0;
      lfsr_q <= `RXPF_LFSR_SEED;
      bitOut_q <= 1'b0;
      bitValid_q <= 1'b0;
    end else if (ce) begin
      bitValid_q <= 1'b0;
      if (lnk.restart) begin
        half_q <= 1'b0;
        lfsr_q <= `RXPF_LFSR_SEED;
      end else if (lnk.chipValid && lnk.active) begin
        if (lnk.decodeSel == `RXPF_DEC_MANCH) begin
          if (!half_q) begin
            first_q <= lnk.chipIn;
            half_q <= 1'b1;
          end else begin
            half_q <= 1'b0;
            bitOut_q <= first_q;
            bitValid_q <= 1'b1;
          end
        end else if (lnk.decodeSel == `RXPF_DEC_WHITE) begin
          bitOut_q <= lnk.chipIn ^ lfsr_q[0];
          bitValid_q <= 1'b1;
          lfsr_q <= {lfsr_q[0] ^ lfsr_q[5], lfsr_q[8:1]};
        end else begin
          bitOut_q <= lnk.chipIn;
          bitValid_q <= 1'b1;
        end
      end
    end
  end

  assign lnk.bitOut = bitOut_q;
  assign lnk.bitValid = bitValid_q;
endmodule // rxpf_line_dec

// *** rxpf_line_if.sv ***
`timescale 1ns/100ps
interface rxpf_line_if;
  logic chipIn;
  logic chipValid;
  logic active;
  logic restart;
  logic [1:0] decodeSel;
  logic bitOut;
  logic bitValid;
  modport dec (input chipIn, input chipValid, input active, input restart, input decodeSel,
               output bitOut, output bitValid);
  modport ctl (output chipIn, output chipValid, output active, output restart, output decodeSel,
               input bitOut, input bitValid);
endinterface

// *** rxpf_pkg.sv ***
package rxpf_pkg;
  typedef logic [7:0] rxpf_byte_t;
  typedef logic [6:0] rxpf_ptr_t;
  typedef enum {HUNT, PAYLOAD, CHKSUM, CRYPT} rxpf_state_e;
endpackage

// *** rxpf_regs.svh ***
// Notes on behaviour
// - Hold one 128-bit key in a 16-byte write-only store, kept through sleep.
// - With decryption on, never decrypt while receiving; the queue only buffers.
// - After a whole packet, decrypt message bytes in place, then flag payload complete.
// - Spend about 7.0 us per 16-byte block before payload complete asserts.
// - Fixed format with decryption: message at most 64, payload at most 65 bytes.
// - Variable format with decryption: message at most 64, payload at most 66 bytes.
// - Checksum covers encrypted data, so its pass flag leads payload complete.
// - Packets not starting with the sync pattern are dropped without any flag.
// - On sync match, start payload reception and raise the frame-match flag.
// - Select 01 accepts local node id; 10 also group id; others discarded.
// - Address check follows sync match and shares the frame-match flag.
// - Length and address bytes stay in the payload and enter the queue.
// - Variable format accepts length below the maximum; maximum 255 skips check.
// - Checksum compares against two received bytes, which never enter the queue.
// - On checksum failure clear queue silently, unless keep-on-fail flags completion.
// - Checksum is CCITT, seeded so leading and trailing zeros are caught.
// - Decode select 01 maps Manchester chips 10 to one and 01 to zero.
// - Manchester covers payload and checksum only; sync stays NRZ at chip rate.
// - Decode select 10 de-whitens payload and checksum with a 9-bit LFSR.
// - Variable format takes the first byte after sync as the byte count.
// - Address byte is second in variable format, first in fixed format.
`ifndef RXPF_REGS_SVH
`define RXPF_REGS_SVH
`define RXPF_QUEUE_DEPTH 66
`define RXPF_KEY_BYTES 16
`define RXPF_CRYPT_MSG_MAX 64
`define RXPF_CLK_PERIOD_NS 8
`define RXPF_BLOCK_TIME_NS 7000
`define RXPF_SYNC_BITS 32
`define RXPF_CRC_POLY 16'h1021
`define RXPF_CRC_SEED 16'h1d0f
`define RXPF_LFSR_SEED 9'h1ff
`define RXPF_LEN_NOCHECK 8'hff
`define RXPF_ADDR_NODE 2'h1
`define RXPF_ADDR_GROUP 2'h2
`define RXPF_DEC_MANCH 2'h1
`define RXPF_DEC_WHITE 2'h2
`endif

// *** rxpf_top.sv ***
`timescale 1ns/100ps
`include "rxpf_regs.svh"
module rxpf_top (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // demodulated chip stream
  input wire logic chipIn,
  input wire logic chipValid,
  // packet configuration
  input wire logic lengthFormatSelect,
  input wire rxpf_pkg::rxpf_byte_t maxPayloadLen,
  input wire logic [1:0] addrFilterSelect,
  input wire rxpf_pkg::rxpf_byte_t localNodeId,
  input wire rxpf_pkg::rxpf_byte_t groupNodeId,
  input wire logic checksumCheckEn,
  input wire logic keepOnChecksumFail,
  input wire logic [1:0] lineDecodeSelect,
  input wire logic decryptEn,
  input wire logic [31:0] syncPattern,
  input wire rxpf_pkg::rxpf_ptr_t queueLevelThresh,
  // key store write port
  input wire logic keyWrEn,
  input wire logic [3:0] keyWrIdx,
  input wire rxpf_pkg::rxpf_byte_t keyWrData,
  // host queue read
  input wire logic rdReq,
  output rxpf_pkg::rxpf_byte_t rdData,
  output logic rdValid,
  // status flags
  input wire logic flagClear,
  output logic payloadCompleteFlag,
  output logic checksumPassFlag,
  output logic queueHasBytesFlag,
  output logic queueLevelFlag,
  output logic frameMatchFlag
);
  import rxpf_pkg::*;

  localparam int BlockCyc = `RXPF_BLOCK_TIME_NS / `RXPF_CLK_PERIOD_NS;
  localparam rxpf_ptr_t Depth = 7'(`RXPF_QUEUE_DEPTH);
  localparam rxpf_ptr_t CryptMax = 7'(`RXPF_CRYPT_MSG_MAX);

  rxpf_state_e state_q;
  logic [`RXPF_SYNC_BITS-1:0] syncSh_q;
  logic [2:0] bitCnt_q;
  logic [6:0] byteSh_q;
  rxpf_byte_t byteNum_q;
  rxpf_byte_t remain_q;
  rxpf_byte_t rxCrc_q;
  logic crcCnt_q;
  rxpf_ptr_t msgStart_q;
  rxpf_ptr_t msgLen_q;
  rxpf_byte_t mem_q [`RXPF_QUEUE_DEPTH];
  rxpf_byte_t key_q [`RXPF_KEY_BYTES];
  rxpf_ptr_t wrPtr_q;
  rxpf_ptr_t rdPtr_q;
  rxpf_ptr_t cnt_q;
  rxpf_ptr_t cryptIdx_q;
  logic [9:0] blkCyc_q;
  rxpf_byte_t rdData_q;
  logic rdValid_q;
  logic payFlag_q;
  logic crcFlag_q;
  logic matchFlag_q;
  logic [15:0] crcVal;
  logic syncHit;

  rxpf_line_if lineIf();

  // chip stream feeds the line decoder only after sync
  assign lineIf.chipIn = chipIn;
  assign lineIf.chipValid = chipValid;
  assign lineIf.active = (state_q == PAYLOAD) || (state_q == CHKSUM);
  assign lineIf.decodeSel = lineDecodeSelect;
  assign lineIf.restart = syncHit;

  rxpf_line_dec uDec (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .lnk(lineIf.dec)
  );

  rxpf_crc16 uCrc (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .init(syncHit),
    .bitEn(lineIf.bitValid && state_q == PAYLOAD),
    .bitIn(lineIf.bitOut),
    .crc(crcVal)
  );

  // wraps a queue index around the queue depth
  function automatic rxpf_ptr_t ptrAdd(input rxpf_ptr_t a, input rxpf_ptr_t b);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, Depth}) begin
      s = s - {1'b0, Depth};
    end
    return s[6:0];
  endfunction

  // decode of the byte just completed
  logic byteDone;
  rxpf_byte_t newByte;
  rxpf_byte_t hdrLen;
  logic isLen;
  logic isAddr;
  logic lenBad;
  logic addrBad;
  logic discard;
  logic payEnd;
  logic crcGood;
  logic endNow;
  logic passOk;
  logic wrEn;
  logic rdFire;
  logic qClear;
  logic cryptStep;
  logic cryptDone;
  logic paySet;
  rxpf_ptr_t cryptEnd;

  assign syncHit = ce && chipValid && state_q == HUNT
                   && {syncSh_q[`RXPF_SYNC_BITS-2:0], chipIn} == syncPattern;
  assign byteDone = ce && lineIf.bitValid && bitCnt_q == 3'h7;
  assign newByte = {byteSh_q, lineIf.bitOut};
  assign hdrLen = {7'h00, lengthFormatSelect} + {7'h00, addrFilterSelect != 2'h0};
  assign isLen = lengthFormatSelect && byteNum_q == 8'h00;
  assign isAddr = addrFilterSelect != 2'h0
                  && byteNum_q == (lengthFormatSelect ? 8'h01 : 8'h00);
  assign lenBad = isLen && maxPayloadLen != `RXPF_LEN_NOCHECK && newByte >= maxPayloadLen;
  assign addrBad = isAddr && newByte != localNodeId
                   && !(addrFilterSelect == `RXPF_ADDR_GROUP && newByte == groupNodeId);
  assign discard = state_q == PAYLOAD && byteDone && (lenBad || addrBad);
  assign payEnd = state_q == PAYLOAD && byteDone && !discard
                  && (isLen ? newByte == 8'h00 : remain_q == 8'h01);
  assign crcGood = ~crcVal == {rxCrc_q, newByte};
  assign endNow = (payEnd && !checksumCheckEn) || (state_q == CHKSUM && byteDone && crcCnt_q);
  assign passOk = !checksumCheckEn || crcGood;
  assign wrEn = state_q == PAYLOAD && byteDone && !discard && cnt_q != Depth;
  assign rdFire = ce && rdReq && cnt_q != 7'h00 && state_q != CRYPT;
  assign qClear = discard || (endNow && !passOk && !keepOnChecksumFail);
  assign cryptEnd = msgLen_q > CryptMax ? CryptMax : msgLen_q;
  assign cryptStep = ce && state_q == CRYPT && blkCyc_q < 10'd16 && cryptIdx_q < cryptEnd;
  assign cryptDone = ce && state_q == CRYPT && blkCyc_q == 10'(BlockCyc - 1) && cryptIdx_q >= cryptEnd;
  assign paySet = (endNow && (passOk || keepOnChecksumFail) && !decryptEn) || cryptDone;

  // raw chip history for sync recognition, kept NRZ
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      syncSh_q <= '0;
    end else if (ce && chipValid) begin
      syncSh_q <= {syncSh_q[`RXPF_SYNC_BITS-2:0], chipIn};
    end
  end

  // packet sequencer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= HUNT;
    end else if (ce) begin
      unique case (state_q)
        HUNT: begin
          if (syncHit) begin
            state_q <= PAYLOAD;
          end
        end
        PAYLOAD: begin
          if (discard) begin
            state_q <= HUNT;
          end else if (payEnd) begin
            state_q <= checksumCheckEn ? CHKSUM : (decryptEn ? CRYPT : HUNT);
          end
        end
        CHKSUM: begin
          if (endNow) begin
            state_q <= (decryptEn && (passOk || keepOnChecksumFail)) ? CRYPT : HUNT;
          end
        end
        CRYPT: begin
          if (cryptDone) begin
            state_q <= HUNT;
          end
        end
      endcase
    end
  end

  // byte assembly and field tracking
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bitCnt_q <= 3'h0;
      byteSh_q <= 7'h00;
      byteNum_q <= 8'h00;
      remain_q <= 8'h00;
      rxCrc_q <= 8'h00;
      crcCnt_q <= 1'b0;
      msgStart_q <= 7'h00;
      msgLen_q <= 7'h00;
    end else if (ce) begin
      if (syncHit) begin
        bitCnt_q <= 3'h0;
        byteNum_q <= 8'h00;
        remain_q <= maxPayloadLen;
        crcCnt_q <= 1'b0;
        msgStart_q <= wrPtr_q;
        msgLen_q <= 7'h00;
      end else if (lineIf.bitValid) begin
        bitCnt_q <= bitCnt_q + 3'h1;
        byteSh_q <= {byteSh_q[5:0], lineIf.bitOut};
      end
      if (state_q == PAYLOAD && byteDone) begin
        byteNum_q <= byteNum_q == 8'hff ? byteNum_q : byteNum_q + 8'h01;
        remain_q <= isLen ? newByte : remain_q - 8'h01;
        if (byteNum_q == hdrLen) begin
          msgStart_q <= wrPtr_q;
        end
        if (byteNum_q >= hdrLen && msgLen_q != 7'h7f) begin
          msgLen_q <= msgLen_q + 7'h01;
        end
      end
      if (state_q == CHKSUM && byteDone) begin
        rxCrc_q <= newByte;
        crcCnt_q <= 1'b1;
      end
    end
  end

  // queue pointers and fill level
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrPtr_q <= 7'h00;
      rdPtr_q <= 7'h00;
      cnt_q <= 7'h00;
    end else if (ce) begin
      if (qClear) begin
        wrPtr_q <= 7'h00;
        rdPtr_q <= 7'h00;
        cnt_q <= 7'h00;
      end else begin
        if (wrEn) begin
          wrPtr_q <= ptrAdd(wrPtr_q, 7'h01);
        end
        if (rdFire) begin
          rdPtr_q <= ptrAdd(rdPtr_q, 7'h01);
        end
        cnt_q <= cnt_q + {6'h00, wrEn} - {6'h00, rdFire};
      end
    end
  end

  // queue storage: payload writes, in-place decryption rewrite
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < `RXPF_QUEUE_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (ce) begin
      if (wrEn) begin
        mem_q[wrPtr_q] <= newByte;
      end else if (cryptStep) begin
        mem_q[ptrAdd(msgStart_q, cryptIdx_q)] <=
          mem_q[ptrAdd(msgStart_q, cryptIdx_q)] ^ key_q[cryptIdx_q[3:0]];
      end
    end
  end

  // write-only key store, untouched by packet activity
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < `RXPF_KEY_BYTES; i++) begin
        key_q[i] <= 8'h00;
      end
    end else if (ce && keyWrEn) begin
      key_q[keyWrIdx] <= keyWrData;
    end
  end

  // block timer: fixed delay per 16-byte block before completion
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cryptIdx_q <= 7'h00;
      blkCyc_q <= 10'h000;
    end else if (ce) begin
      if (state_q != CRYPT) begin
        cryptIdx_q <= 7'h00;
        blkCyc_q <= 10'h000;
      end else begin
        if (cryptStep) begin
          cryptIdx_q <= cryptIdx_q + 7'h01;
        end
        blkCyc_q <= blkCyc_q == 10'(BlockCyc - 1) ? 10'h000 : blkCyc_q + 10'h001;
      end
    end
  end

  // host read port
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else if (ce) begin
      rdValid_q <= rdFire;
      if (rdFire) begin
        rdData_q <= mem_q[rdPtr_q];
      end
    end
  end

  // sticky status flags, a set beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      payFlag_q <= 1'b0;
      crcFlag_q <= 1'b0;
      matchFlag_q <= 1'b0;
    end else if (ce) begin
      if (paySet) begin
        payFlag_q <= 1'b1;
      end else if (flagClear || syncHit) begin
        payFlag_q <= 1'b0;
      end
      if (state_q == CHKSUM && endNow && crcGood) begin
        crcFlag_q <= 1'b1;
      end else if (flagClear || syncHit) begin
        crcFlag_q <= 1'b0;
      end
      if (syncHit) begin
        matchFlag_q <= 1'b1;
      end else if (flagClear || discard || qClear) begin
        matchFlag_q <= 1'b0;
      end
    end
  end

  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign payloadCompleteFlag = payFlag_q;
  assign checksumPassFlag = crcFlag_q;
  assign frameMatchFlag = matchFlag_q;
  assign queueHasBytesFlag = cnt_q != 7'h00;
  assign queueLevelFlag = cnt_q > queueLevelThresh;
endmodule // rxpf_top

// *** rxpf_top_assertions.sv ***
`timescale 1ns/100ps
module rxpf_top_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // watched inputs
  input wire logic chipIn,
  input wire logic chipValid,
  input wire logic decryptEn,
  input wire logic [31:0] syncPattern,
  input wire logic rdReq,
  // watched outputs
  input wire logic rdValid,
  input wire logic payloadCompleteFlag,
  input wire logic checksumPassFlag,
  input wire logic queueHasBytesFlag,
  input wire logic queueLevelFlag,
  input wire logic frameMatchFlag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // frame match only follows a taken chip equal to the last sync chip
  a_sync_cause: assert property ($rose(frameMatchFlag) |-> $past(chipValid && ce) && $past(chipIn) == $past(syncPattern[0]))
    else $error("frame match without sync chip");
  a_reset_clear: assert property ($rose(rst_b) |-> !rdValid && !frameMatchFlag && !payloadCompleteFlag)
    else $error("flags set after reset");
  a_read_cause: assert property (rdValid |-> $past(rdReq && queueHasBytesFlag))
    else $error("byte delivered without request");
  a_empty_quiet: assert property (!queueHasBytesFlag |=> !rdValid)
    else $error("byte delivered from empty queue");
  a_level_bytes: assert property (queueLevelFlag |-> queueHasBytesFlag)
    else $error("level flag on empty queue");
  a_done_frame: assert property ($rose(payloadCompleteFlag) |-> frameMatchFlag)
    else $error("payload complete without frame match");
  a_plain_done: assert property ($rose(checksumPassFlag) && !decryptEn |-> payloadCompleteFlag)
    else $error("payload complete late without decryption");
  a_crypt_delay: assert property ($rose(checksumPassFlag) && decryptEn |-> (!payloadCompleteFlag) [*8])
    else $error("payload complete too early with decryption");
  a_crypt_noread: assert property (decryptEn && checksumPassFlag && !payloadCompleteFlag |=> !rdValid)
    else $error("byte delivered while decrypting");
  // main scenarios reached
  c_frame: cover property ($rose(frameMatchFlag));
  c_crypt: cover property ($rose(payloadCompleteFlag) && decryptEn);
  c_level: cover property (rdValid && queueLevelFlag);
endmodule // rxpf_top_assertions

bind rxpf_top rxpf_top_assertions chk_u (.mclk, .rst_b, .ce, .chipIn, .chipValid, .decryptEn, .syncPattern,
  .rdReq, .rdValid, .payloadCompleteFlag, .checksumPassFlag, .queueHasBytesFlag, .queueLevelFlag, .frameMatchFlag);

// *** tb_rxpf_top.sv ***
`timescale 1ns/100ps
module tb_rxpf_top;
  import rxpf_pkg::*;
  typedef rxpf_byte_t rxpf_queue_t[$];
  // design and model signals
  logic mclk, rst_b, ce, chipIn, chipValid, lengthFormatSelect, checksumCheckEn, keepOnChecksumFail, decryptEn;
  logic keyWrEn, rdReq, rdValid, flagClear, drainEn, hostSlow;
  logic payloadCompleteFlag, checksumPassFlag, queueHasBytesFlag, queueLevelFlag, frameMatchFlag;
  logic [1:0] addrFilterSelect, lineDecodeSelect;
  logic [3:0] keyWrIdx;
  logic [31:0] syncPattern;
  rxpf_byte_t maxPayloadLen, localNodeId, groupNodeId, keyWrData, rdData;
  rxpf_ptr_t queueLevelThresh;
  rxpf_queue_t expQ, p;
  rxpf_byte_t key[16];
  logic [8:0] wht;
  int errCount, cmpCount, lastGap;

  rxpf_top dut_u (.mclk, .rst_b, .ce, .chipIn, .chipValid, .lengthFormatSelect, .maxPayloadLen, .addrFilterSelect,
    .localNodeId, .groupNodeId, .checksumCheckEn, .keepOnChecksumFail, .lineDecodeSelect, .decryptEn, .syncPattern,
    .queueLevelThresh, .keyWrEn, .keyWrIdx, .keyWrData, .rdReq, .rdData, .rdValid, .flagClear, .payloadCompleteFlag,
    .checksumPassFlag, .queueHasBytesFlag, .queueLevelFlag, .frameMatchFlag);
  rxpf_host_model host_u (.mclk, .rst_b, .drainEn, .slow(hostSlow), .queueHasBytesFlag, .rdReq);

  // clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chkByte(input rxpf_byte_t got, input rxpf_byte_t exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: byte %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkFlag(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: flag %b exp %b", $time, got, exp);
    end
  endtask

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // expected checksum: ccitt, seeded, msb first, sent inverted
  function automatic logic [15:0] crcOf(input rxpf_queue_t q);
    logic [15:0] c;
    logic fb;
    c = 16'h1d0f;
    foreach (q[i]) begin
      for (int j = 7; j >= 0; j--) begin
        fb = c[15] ^ q[i][j];
        c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
    return ~c;
  endfunction

  function automatic rxpf_queue_t mk(input int n);
    rxpf_queue_t q;
    repeat (n) q.push_back(8'($urandom));
    return q;
  endfunction

  task automatic chip(input logic b);
    @(posedge mclk);
    chipIn <= b;
    chipValid <= 1'b1;
    @(posedge mclk);
    chipValid <= 1'b0;
  endtask

  task automatic sbyte(input rxpf_byte_t b);
    for (int i = 7; i >= 0; i--) begin
      chip(b[i] ^ (lineDecodeSelect == 2'h2 && wht[8]));
      wht = {wht[7:0], wht[8] ^ wht[3]};
      if (lineDecodeSelect == 2'h1) chip(~b[i]);
    end
  endtask

  // send one frame, wait for the flags, check them, then drain and clear
  task automatic run(input string nm, input rxpf_queue_t q, input logic [31:0] sp, input logic bad, fm, cp, pc);
    logic [15:0] c;
    int n;
    c = crcOf(q) ^ {15'h0000, bad};
    wht = 9'h1ff;
    for (int i = 31; i >= 0; i--) chip(sp[i]);
    foreach (q[i]) sbyte(q[i]);
    sbyte(c[15:8]);
    sbyte(c[7:0]);
    n = 0;
    while (checksumPassFlag !== 1'b1 && payloadCompleteFlag !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    lastGap = 0;
    while (payloadCompleteFlag !== 1'b1 && lastGap < 2000) begin
      @(posedge mclk);
      lastGap++;
    end
    repeat (2) @(posedge mclk);
    chkFlag(frameMatchFlag, fm);
    chkFlag(checksumPassFlag, cp);
    chkFlag(payloadCompleteFlag, pc);
    if (!drainEn) chkFlag(queueLevelFlag, logic'(expQ.size() > queueLevelThresh));
    drainEn <= 1'b1;
    n = 0;
    while (queueHasBytesFlag !== 1'b0 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    repeat (3) @(posedge mclk);
    drainEn <= 1'b0;
    flagClear <= 1'b1;
    @(posedge mclk);
    flagClear <= 1'b0;
    chkFlag(logic'(expQ.size() == 0), 1'b1);
    $display("test %s done", nm);
  endtask

  // compare every delivered byte with the oldest note
  always @(posedge mclk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        errCount++;
        $display("wrong value at %0t: unexpected byte", $time);
      end else begin
        chkByte(rdData, expQ.pop_front());
      end
    end
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    errCount++;
    $display("wrong value at %0t: watchdog expired", $time);
    finalReport();
  end

  // stimulus
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    chipIn = 1'b0;
    chipValid = 1'b0;
    keyWrEn = 1'b0;
    keyWrIdx = 4'h0;
    keyWrData = 8'h00;
    flagClear = 1'b0;
    drainEn = 1'b0;
    hostSlow = 1'b0;
    lengthFormatSelect = 1'b1;
    maxPayloadLen = 8'hff;
    addrFilterSelect = 2'h0;
    localNodeId = 8'h5a;
    groupNodeId = 8'ha5;
    checksumCheckEn = 1'b1;
    keepOnChecksumFail = 1'b0;
    lineDecodeSelect = 2'h0;
    decryptEn = 1'b0;
    void'($urandom(17875));
    for (int i = 0; i < 4; i++) syncPattern[8*i+:8] = 8'($urandom_range(255, 1));
    queueLevelThresh = 7'($urandom_range(20, 1));
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      key[i] = 8'($urandom);
      keyWrEn <= 1'b1;
      keyWrIdx <= 4'(i);
      keyWrData <= key[i];
    end
    @(posedge mclk);
    keyWrEn <= 1'b0;
    p = mk(11);
    p[0] = 8'h0a;
    foreach (p[i]) expQ.push_back(p[i]);
    run("variable", p, syncPattern, 1'b0, 1'b1, 1'b1, 1'b1);
    maxPayloadLen <= 8'h06;
    for (int l = 5; l < 7; l++) begin
      p = mk(l + 1);
      p[0] = 8'(l);
      if (l < 6) foreach (p[i]) expQ.push_back(p[i]);
      run("length", p, syncPattern, 1'b0, l < 6, l < 6, l < 6);
    end
    maxPayloadLen <= 8'hff;
    for (int k = 0; k < 3; k++) begin
      addrFilterSelect <= (k == 2) ? 2'h2 : 2'h1;
      p = mk(6);
      p[0] = 8'h05;
      p[1] = (k == 0) ? localNodeId : groupNodeId;
      if (k != 1) foreach (p[i]) expQ.push_back(p[i]);
      run("address", p, syncPattern, 1'b0, k != 1, k != 1, k != 1);
    end
    addrFilterSelect <= 2'h0;
    p = mk(6);
    p[0] = 8'h05;
    run("nosync", p, syncPattern ^ 32'h0001_0000, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      keepOnChecksumFail <= k[0];
      checksumCheckEn <= (k < 2);
      p = mk(8);
      p[0] = 8'h07;
      if (k != 0) foreach (p[i]) expQ.push_back(p[i]);
      run("checksum", p, syncPattern, 1'b1, k != 0, 1'b0, k != 0);
    end
    keepOnChecksumFail <= 1'b0;
    checksumCheckEn <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      lineDecodeSelect <= 2'(s);
      p = mk(9);
      p[0] = 8'h08;
      foreach (p[i]) expQ.push_back(p[i]);
      run("decode", p, syncPattern, 1'b0, 1'b1, 1'b1, 1'b1);
    end
    lineDecodeSelect <= 2'h0;
    lengthFormatSelect <= 1'b0;
    maxPayloadLen <= 8'h14;
    addrFilterSelect <= 2'h1;
    decryptEn <= 1'b1;
    hostSlow <= 1'b1;
    p = mk(20);
    p[0] = localNodeId;
    expQ.push_back(p[0]);
    for (int i = 1; i < 20; i++) expQ.push_back(p[i] ^ key[(i - 1) % 16]);
    run("decrypt", p, syncPattern, 1'b0, 1'b1, 1'b1, 1'b1);
    chkFlag(logic'(lastGap >= 1749 && lastGap <= 1752), 1'b1);
    lengthFormatSelect <= 1'b1;
    maxPayloadLen <= 8'hff;
    addrFilterSelect <= 2'h0;
    decryptEn <= 1'b0;
    hostSlow <= 1'b0;
    drainEn <= 1'b1;
    p = mk(71);
    p[0] = 8'h46;
    foreach (p[i]) expQ.push_back(p[i]);
    run("large", p, syncPattern, 1'b0, 1'b1, 1'b1, 1'b1);
    finalReport();
  end
endmodule // tb_rxpf_top
